//--- logic/wheel_motor_params.svh
`ifndef WHEEL_MOTOR_PARAMS_SVH
`define WHEEL_MOTOR_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and PWM timing
// ----------------------------------------------------------------------
`define WM_CLK_HZ               16000000
`define WM_PWM_HZ               20000

// ----------------------------------------------------------------------
// Widths and wheel indices
// ----------------------------------------------------------------------
`define WM_PWM_BITS             8
`define WM_COUNT_BITS           16
`define WM_WHEELS               2
`define WM_RIGHT                0
`define WM_LEFT                 1

// ----------------------------------------------------------------------
// Encoder resolution, for software scaling of the counts
// ----------------------------------------------------------------------
`define WM_MOTOR_COUNTS_PER_REV 12
`define WM_WHEEL_COUNTS_PER_REV 1440

`endif

//--- logic/wheel_motor_pkg.sv
package wheel_motor_pkg;

    // Direction line levels seen by the H-bridge drivers.
    typedef enum logic {
        DIR_FORWARD = 1'h0,
        DIR_REVERSE = 1'h1
    } dir_t;

endpackage : wheel_motor_pkg

//--- logic/quad_if.sv
`timescale 1ns/1ns
`include "wheel_motor_params.svh"

// Carries one encoder's pins in and its decoded state out.
interface quad_if #(
    parameter int COUNT_BITS = `WM_COUNT_BITS
);
    logic                         enc_xor;
    logic                         enc_b;
    logic signed [COUNT_BITS-1:0] count;
    logic                         edge_evt;
    logic                         forward;

    modport dec (input enc_xor, input enc_b, output count, output edge_evt, output forward);
    modport top (output enc_xor, output enc_b, input count, input edge_evt, input forward);
endinterface : quad_if

//--- logic/quad_decoder.sv
`timescale 1ns/1ns
`include "wheel_motor_params.svh"

module quad_decoder #(
    parameter int COUNT_BITS = `WM_COUNT_BITS
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    quad_if.dec       port
);
    import wheel_motor_pkg::*;

    typedef struct packed {
        logic                         primed;
        logic                         xor_prev;
        logic                         b_prev;
        logic                         edge_evt;
        logic                         fwd;
        logic signed [COUNT_BITS-1:0] count;
    } dec_state_t;

    dec_state_t s_reg;
    dec_state_t s_next;
    logic       a_now;
    logic       xor_edge;

    // ------------------------------------------------------------------
    // Edge detection and counting
    // ------------------------------------------------------------------
    // The first cycle after reset only primes the history, so a reset value
    // that differs from the pins cannot fake an edge.
    always_comb begin
        a_now           = port.enc_xor ^ port.enc_b;
        xor_edge        = s_reg.primed && (port.enc_xor != s_reg.xor_prev);
        s_next          = s_reg;
        s_next.primed   = 1'h1;
        s_next.xor_prev = port.enc_xor;
        s_next.b_prev   = port.enc_b;
        s_next.edge_evt = xor_edge;
        if (xor_edge) begin
            // Forward: the new A equals the old B (B leads A).
            s_next.fwd = (a_now == s_reg.b_prev);
            if (a_now == s_reg.b_prev) begin
                s_next.count = s_reg.count + COUNT_BITS'(1);
            end else begin
                s_next.count = s_reg.count - COUNT_BITS'(1);
            end
        end
    end

    // Count wraps in two's complement; software reads it often enough.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign port.count    = s_reg.count;
    assign port.edge_evt = s_reg.edge_evt;
    assign port.forward  = s_reg.fwd;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_count_fwd_step: assert property (xor_edge && ((port.enc_xor ^ port.enc_b) == s_reg.b_prev)
        |=> s_reg.count == COUNT_BITS'($past(s_reg.count) + COUNT_BITS'(1)) && s_reg.fwd)
        else $error("Forward edge did not raise the count by one.");
    a_count_rev_step: assert property (xor_edge && ((port.enc_xor ^ port.enc_b) != s_reg.b_prev)
        |=> s_reg.count == COUNT_BITS'($past(s_reg.count) - COUNT_BITS'(1)) && !s_reg.fwd)
        else $error("Reverse edge did not lower the count by one.");
    a_count_hold_idle: assert property (s_reg.primed && $stable(port.enc_xor) |=> $stable(s_reg.count))
        else $error("Count moved without a combined-input edge.");
    a_edge_every_toggle: assert property (s_reg.primed && (port.enc_xor != $past(port.enc_xor))
        |=> port.edge_evt)
        else $error("Combined-input edge was not reported.");

    c_fwd_run: cover property (port.edge_evt && port.forward ##[1:100] port.edge_evt && port.forward);
    c_rev_run: cover property (port.edge_evt && !port.forward ##[1:100] port.edge_evt && !port.forward);

endmodule : quad_decoder

//--- logic/wheel_motor_encoder_io.sv
`timescale 1ns/1ns
`include "wheel_motor_params.svh"

module wheel_motor_encoder_io #(
    parameter int CLK_HZ     = `WM_CLK_HZ,
    parameter int PWM_HZ     = `WM_PWM_HZ,
    parameter int PWM_BITS   = `WM_PWM_BITS,
    parameter int COUNT_BITS = `WM_COUNT_BITS
) (
    input  wire logic                          I_CLK,
    input  wire logic                          I_RST_N,
    input  wire logic                          I_RIGHT_REVERSE,
    input  wire logic                          I_LEFT_REVERSE,
    input  wire logic [PWM_BITS-1:0]           I_RIGHT_SPEED,
    input  wire logic [PWM_BITS-1:0]           I_LEFT_SPEED,
    input  wire logic                          I_RIGHT_ENC_XOR,
    input  wire logic                          I_RIGHT_ENC_B,
    input  wire logic                          I_LEFT_ENC_XOR,
    input  wire logic                          I_LEFT_ENC_B,
    output wheel_motor_pkg::dir_t              O_RIGHT_DIR,
    output wheel_motor_pkg::dir_t              O_LEFT_DIR,
    output logic                               O_RIGHT_PWM,
    output logic                               O_LEFT_PWM,
    output logic signed [COUNT_BITS-1:0]       O_RIGHT_COUNT,
    output logic signed [COUNT_BITS-1:0]       O_LEFT_COUNT,
    output logic                               O_RIGHT_EDGE,
    output logic                               O_LEFT_EDGE,
    output logic                               O_RIGHT_FWD,
    output logic                               O_LEFT_FWD
);
    import wheel_motor_pkg::*;

    // ------------------------------------------------------------------
    // Derived timing
    // ------------------------------------------------------------------
    localparam int WHEELS  = `WM_WHEELS;
    localparam int PWM_TOP = (1 << PWM_BITS) - 2;   // Last counter value; full duty stays high.
    localparam int RAW_DIV = CLK_HZ / (PWM_HZ * (PWM_TOP + 1));
    localparam int DIV     = (RAW_DIV < 1) ? 1 : RAW_DIV;
    localparam int DIV_W   = (DIV > 1) ? $clog2(DIV) : 1;

    // Refuse widths the counters and struct cannot hold.
    generate
        if (PWM_BITS < 2 || PWM_BITS > 16 || COUNT_BITS < 2 || COUNT_BITS > 32 || CLK_HZ < 1) begin : g_bad_param
            $error("wheel_motor_encoder_io: unsupported parameter value");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // Reset asserts at once but releases on a clock edge, so no flop sees
    // the release near its clock.
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta_reg <= 1'h0;
            rst_n_reg    <= 1'h0;
        end else begin
            rst_meta_reg <= 1'h1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Motor state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DIV_W-1:0]                div_cnt;
        logic                            tick;
        logic [PWM_BITS-1:0]             pwm_cnt;
        logic [WHEELS-1:0][PWM_BITS-1:0] duty;
        logic [WHEELS-1:0]               pwm;
        dir_t [WHEELS-1:0]               dir;
    } motor_state_t;

    motor_state_t                    s_reg;
    motor_state_t                    s_next;
    logic [WHEELS-1:0][PWM_BITS-1:0] speed_in;
    logic [WHEELS-1:0]               reverse_in;
    logic                            period_end;

    assign speed_in[`WM_RIGHT]   = I_RIGHT_SPEED;
    assign speed_in[`WM_LEFT]    = I_LEFT_SPEED;
    assign reverse_in[`WM_RIGHT] = I_RIGHT_REVERSE;
    assign reverse_in[`WM_LEFT]  = I_LEFT_REVERSE;
    assign period_end            = s_reg.tick && (s_reg.pwm_cnt == PWM_BITS'(PWM_TOP));

    // Prescaler tick, shared PWM counter, per-motor duty and direction.
    // Duty is taken only at the period boundary so a speed change never
    // cuts a pulse short.
    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'h0;
        if (s_reg.div_cnt == DIV_W'(DIV - 1)) begin
            s_next.div_cnt = '0;
            s_next.tick    = 1'h1;
        end else begin
            s_next.div_cnt = s_reg.div_cnt + DIV_W'(1);
        end
        if (period_end) begin
            s_next.pwm_cnt = '0;
        end else if (s_reg.tick) begin
            s_next.pwm_cnt = s_reg.pwm_cnt + PWM_BITS'(1);
        end
        for (int w = 0; w < WHEELS; w++) begin
            s_next.dir[w] = reverse_in[w] ? DIR_REVERSE : DIR_FORWARD;
            if (period_end) begin
                s_next.duty[w] = speed_in[w];
            end
            s_next.pwm[w] = (s_next.pwm_cnt < s_next.duty[w]);
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign O_RIGHT_DIR = s_reg.dir[`WM_RIGHT];
    assign O_LEFT_DIR  = s_reg.dir[`WM_LEFT];
    assign O_RIGHT_PWM = s_reg.pwm[`WM_RIGHT];
    assign O_LEFT_PWM  = s_reg.pwm[`WM_LEFT];

    // ------------------------------------------------------------------
    // Encoder decoders
    // ------------------------------------------------------------------
    // The board already merges A and B into one combined line; each
    // decoder watches it on every clock, far faster than any encoder.
    logic [WHEELS-1:0] enc_xor_in;
    logic [WHEELS-1:0] enc_b_in;

    assign enc_xor_in[`WM_RIGHT] = I_RIGHT_ENC_XOR;
    assign enc_xor_in[`WM_LEFT]  = I_LEFT_ENC_XOR;
    assign enc_b_in[`WM_RIGHT]   = I_RIGHT_ENC_B;
    assign enc_b_in[`WM_LEFT]    = I_LEFT_ENC_B;

    quad_if #(.COUNT_BITS(COUNT_BITS)) enc_bus [WHEELS] ();

    generate
        for (genvar w = 0; w < WHEELS; w++) begin : g_wheel
            assign enc_bus[w].enc_xor = enc_xor_in[w];
            assign enc_bus[w].enc_b   = enc_b_in[w];

            quad_decoder #(
                .COUNT_BITS (COUNT_BITS)
            ) u_decoder (
                .i_clk   (I_CLK),
                .i_rst_n (rst_n_reg),
                .port    (enc_bus[w].dec)
            );
        end
    endgenerate

    // Right and left encoder edge events and counts, straight from decoder flops.
    assign O_RIGHT_COUNT = enc_bus[`WM_RIGHT].count;
    assign O_LEFT_COUNT  = enc_bus[`WM_LEFT].count;
    assign O_RIGHT_EDGE  = enc_bus[`WM_RIGHT].edge_evt;
    assign O_LEFT_EDGE   = enc_bus[`WM_LEFT].edge_evt;
    assign O_RIGHT_FWD   = enc_bus[`WM_RIGHT].forward;
    assign O_LEFT_FWD    = enc_bus[`WM_LEFT].forward;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!rst_n_reg);

    a_right_dir_pol: assert property (##1 1'h1 |-> O_RIGHT_DIR == ($past(I_RIGHT_REVERSE) ? DIR_REVERSE : DIR_FORWARD))
        else $error("Right direction line has wrong level.");
    a_left_dir_pol: assert property (I_LEFT_REVERSE ##1 I_LEFT_REVERSE |-> O_LEFT_DIR == DIR_REVERSE ##1 1'h1)
        else $error("Left direction line not high for reverse.");
    a_pwm_rise_start: assert property ($rose(O_RIGHT_PWM) |-> s_reg.pwm_cnt == '0)
        else $error("Right PWM rose inside a PWM period.");
    a_duty_only_boundary: assert property (!period_end |=> $stable(s_reg.duty))
        else $error("Duty changed inside a PWM period.");
    a_full_duty_on: assert property (s_reg.duty[`WM_LEFT] == '1 && $stable(s_reg.duty[`WM_LEFT]) |-> O_LEFT_PWM)
        else $error("Full duty did not hold left PWM high.");

    c_right_pwm_pulse: cover property ($rose(O_RIGHT_PWM) ##[1:1000] $fell(O_RIGHT_PWM));
    c_left_reverse_edge: cover property (O_LEFT_DIR == DIR_REVERSE && O_LEFT_EDGE && !O_LEFT_FWD);
    c_right_fwd_edge: cover property (O_RIGHT_EDGE && O_RIGHT_FWD);

endmodule : wheel_motor_encoder_io

//--- testbench/wheel_partner.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Encoder boards for both wheels
// ----------------------------------------------------------------------
module wheel_partner (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_step,
    input  wire logic [1:0] i_fwd,
    output logic      [1:0] o_enc_xor,
    output logic      [1:0] o_enc_b
);
    // Each wheel starts at rest with both channels low.
    logic [1:0] phase_reg [2] = '{2'h0, 2'h0};

    // One quadrature step per request; a real shaft never skips a phase.
    always @(posedge i_clk) begin
        for (int w = 0; w < 2; w++) begin
            if (i_step[w]) begin
                phase_reg[w] <= i_fwd[w] ? phase_reg[w] + 2'h1 : phase_reg[w] - 2'h1;
            end
        end
    end

    // Phases 1 and 2 hold B high and phases 2 and 3 hold A high, so B leads A forward.
    always_comb begin
        for (int w = 0; w < 2; w++) begin
            o_enc_b[w]   = (phase_reg[w] == 2'h1) || (phase_reg[w] == 2'h2);
            o_enc_xor[w] = phase_reg[w][1] ^ o_enc_b[w];
        end
    end
endmodule : wheel_partner

//--- testbench/testbench.sv
`timescale 1ns/1ns

module testbench;
    import wheel_motor_pkg::*;

    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [1:0]        rev = 2'h0;
    logic [2:0]        spd [2];
    logic [1:0]        step = 2'h0;
    logic [1:0]        fwd = 2'h0;
    logic [1:0]        enc_xor;
    logic [1:0]        enc_b;
    dir_t              dir [2];
    logic [1:0]        pwm;
    logic signed [15:0] cnt [2];
    logic [1:0]        edge_seen;
    logic [1:0]        fwd_seen;
    logic signed [15:0] exp_cnt [2];
    int                bad_count = 0;
    int                total_checks = 0;

    // ------------------------------------------------------------------
    // Clock and design
    // ------------------------------------------------------------------
    // The period is fixed; the PWM timing is rescaled by parameters. 
    always #4 clk = ~clk;

    // A three-bit duty with one tick per clock keeps the PWM period at seven clocks.
    wheel_motor_encoder_io #(.CLK_HZ(16000000), .PWM_HZ(16000000), .PWM_BITS(3), .COUNT_BITS(16)) dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_RIGHT_REVERSE(rev[0]), .I_LEFT_REVERSE(rev[1]),
        .I_RIGHT_SPEED(spd[0]), .I_LEFT_SPEED(spd[1]), .I_RIGHT_ENC_XOR(enc_xor[0]),
        .I_RIGHT_ENC_B(enc_b[0]), .I_LEFT_ENC_XOR(enc_xor[1]), .I_LEFT_ENC_B(enc_b[1]),
        .O_RIGHT_DIR(dir[0]), .O_LEFT_DIR(dir[1]), .O_RIGHT_PWM(pwm[0]), .O_LEFT_PWM(pwm[1]),
        .O_RIGHT_COUNT(cnt[0]), .O_LEFT_COUNT(cnt[1]), .O_RIGHT_EDGE(edge_seen[0]),
        .O_LEFT_EDGE(edge_seen[1]), .O_RIGHT_FWD(fwd_seen[0]), .O_LEFT_FWD(fwd_seen[1])
    );

    wheel_partner partner (.i_clk(clk), .i_step(step), .i_fwd(fwd), .o_enc_xor(enc_xor), .o_enc_b(enc_b));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expected);
        total_checks++;
        if (seen !== expected) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, expected, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Waits a bounded time for the event pulse of one wheel.
    task automatic wait_edge(input int w);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            if (edge_seen[w] === 1'b1) begin
                return;
            end
        end
        bad_count++;
        $display("unexpected timeout waiting for encoder event on wheel %0d", w);
        print_verdict();
    endtask : wait_edge

    // Moves one wheel by one step and checks the count and direction that follow.
    task automatic enc_step(input int w, input logic dir_fwd);
        @(posedge clk);
        step[w] <= 1'b1;
        fwd[w]  <= dir_fwd;
        @(posedge clk);
        step[w] <= 1'b0;
        wait_edge(w);
        exp_cnt[w] = dir_fwd ? exp_cnt[w] + 16'sh0001 : exp_cnt[w] - 16'sh0001;
        check("count", cnt[w], exp_cnt[w]);
        check("forward flag", {15'h0, fwd_seen[w]}, {15'h0, dir_fwd});
        @(posedge clk);
        #1;
        check("event width", {15'h0, edge_seen[w]}, 16'h0000);
    endtask : enc_step

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset;
        check("right count after reset", cnt[0], 16'h0000);
        check("left count after reset", cnt[1], 16'h0000);
        check("pwm after reset", {14'h0, pwm}, 16'h0000);
        check("event after reset", {14'h0, edge_seen}, 16'h0000);
        $display("test reset done");
    endtask : test_reset

    task automatic test_direction;
        for (int v = 0; v < 4; v++) begin
            @(posedge clk);
            rev <= v[1:0];
            @(posedge clk);
            @(posedge clk);
            #1;
            check("right dir", {15'h0, dir[0]}, {15'h0, v[0]});
            check("left dir", {15'h0, dir[1]}, {15'h0, v[1]});
        end
        $display("test direction done");
    endtask : test_direction

    // Duty d gives d high clocks in every seven, with full scale always on.
    task automatic test_pwm;
        int hi [2];
        for (int d = 0; d < 8; d += 3) begin
            @(posedge clk);
            spd[0] <= d[2:0];
            spd[1] <= 3'h7 - d[2:0];
            repeat (21) @(posedge clk);
            hi[0] = 0;
            hi[1] = 0;
            for (int i = 0; i < 7; i++) begin
                @(posedge clk);
                #1;
                for (int w = 0; w < 2; w++) begin
                    if (pwm[w] === 1'b1) hi[w]++;
                end
            end
            check("right duty", hi[0][15:0], (d > 7 ? 16'h7 : d[15:0]));
            check("left duty", hi[1][15:0], 16'h7 - d[15:0]);
        end
        $display("test pwm done");
    endtask : test_pwm

    task automatic test_encoder;
        for (int i = 0; i < 5; i++) enc_step(0, 1'b1);
        for (int i = 0; i < 3; i++) enc_step(1, 1'b0);
        enc_step(0, 1'b0);
        enc_step(1, 1'b1);
        check("right count idle wheel", cnt[0], exp_cnt[0]);
        $display("test encoder done");
    endtask : test_encoder

    // Steps on every clock must all be counted, none merged or lost.
    task automatic test_burst;
        @(posedge clk);
        step  <= 2'h3;
        fwd   <= 2'h1;
        repeat (6) @(posedge clk);
        step  <= 2'h0;
        repeat (6) @(posedge clk);
        #1;
        check("right burst count", cnt[0], exp_cnt[0] + 16'sh0006);
        check("left burst count", cnt[1], exp_cnt[1] - 16'sh0006);
        $display("test burst done");
    endtask : test_burst

    // A reset in mid-run clears counts and PWM and must not fake an edge on release.
    task automatic test_mid_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        exp_cnt[0] = 16'sh0000;
        exp_cnt[1] = 16'sh0000;
        check("right count after mid reset", cnt[0], exp_cnt[0]);
        check("left count after mid reset", cnt[1], exp_cnt[1]);
        check("pwm after mid reset", {14'h0, pwm}, 16'h0000);
        check("event after mid reset", {14'h0, edge_seen}, 16'h0000);
        check("dir after mid reset", {14'h0, dir[1], dir[0]}, {14'h0, rev});
        enc_step(0, 1'b1);
        $display("test mid reset done");
    endtask : test_mid_reset

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        exp_cnt[0] = 16'sh0000;
        exp_cnt[1] = 16'sh0000;
        spd[0] = 3'h0;
        spd[1] = 3'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        test_reset();
        test_direction();
        test_pwm();
        test_encoder();
        test_burst();
        test_mid_reset();
        print_verdict();
    end
endmodule : testbench
